// >>> occb_bank.sv
// Purpose: AHB-Lite register bank for output channel configuration
// Assumes: one clock, word-sized single transfers, wait states only while ce is low
// Notes:   decoded settings are registered one cycle after storage
//
// What this block does
// - 20-bit divide ratio from three bytes
// - phase field steers both single-ended pins
// - coarse delay 0..63 oscillator periods
// - two-bit fine delay, 30 ps steps
// - three-bit fine delay, up to four steps
// - supply code 00/01/10, 11 undefined
// - driver standard codes 000 to 101
// - external, pull-up, pull-down termination codes
// - CMOS on positive, negative or both pins
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module occb_bank
  import occb_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // output channel 4 settings
  output logic [19:0]      out4DivideRatio,
  output logic             out4PositivePinSource,
  output logic             out4NegativePinSource,
  output logic [2:0]       out4DriveStrength,
  output logic [5:0]       out4CoarseDelay,
  output logic [7:0]       out4FineDelayPs,
  output logic [7:0]       out4ExtFineDelayPs,
  output logic [1:0]       out4SupplyLevelSelect,
  output logic             out4SupplyValid,
  output logic [2:0]       out4DriverStandardSelect,
  output logic             out4DriverValid,
  output logic             out4ExtTerm,
  output logic             out4PullUp,
  output logic             out4PullDown,
  output logic             out4CmosPos,
  output logic             out4CmosNeg,
  output logic             out4TermValid,
  // output channel 5 settings
  output logic [19:0]      out5DivideRatio,
  output logic             out5PositivePinSource,
  output logic             out5NegativePinSource,
  output logic [2:0]       out5DriveStrength
);
  import occb_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  // slot number of a byte address
  function automatic logic [3:0] slotOf(input logic [31:0] a);
    logic [7:0] d;
    d = a[9:2] - IDX_OUT4_DIVIDE_HIGH;
    return d[3:0];
  endfunction

  // mapped word: aligned, in range, not the gap
  function automatic logic isMapped(input logic [31:0] a);
    return (a[31:10] == 22'h0) && (a[1:0] == 2'h0) && (a[9:2] >= IDX_OUT4_DIVIDE_HIGH)
      && (a[9:2] <= IDX_OUT5_PHASE_STRENGTH) && (a[9:2] != IDX_GAP);
  endfunction

  function automatic logic [19:0] divRatio(input logic [7:0] hi, input logic [7:0] mid,
                                           input logic [7:0] lo);
    return {hi[DIVHI_MSB:0], mid, lo};
  endfunction

  // pin sources, 0 true clock, 1 complement
  function automatic logic [1:0] pinSel(input logic [1:0] ph);
    case (ph)
      PH_NORMAL: pinSel = 2'h1;
      PH_TRUE2:  pinSel = 2'h0;
      PH_COMP2:  pinSel = 2'h3;
      default:   pinSel = 2'h2;
    endcase
  endfunction

  function automatic logic [7:0] stepsPs(input logic [2:0] s);
    logic [7:0] p;
    p = 8'(FINE_STEP_PS);
    return 8'({5'h0, s} * p);
  endfunction

  // ****************************************
  // bus slave
  // ****************************************
  logic [7:0]  regs_ff [NUM_SLOTS];
  logic        wrPend_ff;
  logic [3:0]  wrSlot_ff;
  logic [31:0] hrdata_ff;
  logic        take;
  logic [3:0]  aSlot;
  logic        aMapped;
  logic        fwd;

  // frozen clock enable stretches the data phase
  assign hreadyout = ce;
  assign hresp     = 1'h0;
  assign hrdata    = hrdata_ff;
  assign take      = hsel && hready && htrans[1] && ce;
  assign aSlot     = slotOf(haddr);
  assign aMapped   = isMapped(haddr);
  // read right after a write to the same word sees the new byte
  assign fwd       = wrPend_ff && (wrSlot_ff == aSlot);

  // address phase capture of writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPend_ff <= 1'h0;
      wrSlot_ff <= 4'h0;
    end else if (ce) begin
      wrPend_ff <= take && hwrite && aMapped;
      wrSlot_ff <= aSlot;
    end
  end

  // byte storage, spares kept as plain bits
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        regs_ff[i] <= REG_RST;
      end
    end else if (ce && wrPend_ff) begin
      regs_ff[wrSlot_ff] <= hwdata[7:0];
    end
  end

  // read data, unmapped words read zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hrdata_ff <= 32'h0;
    end else if (ce && take && !hwrite) begin
      if (!aMapped) begin
        hrdata_ff <= 32'h0;
      end else if (fwd) begin
        hrdata_ff <= {24'h0, hwdata[7:0]};
      end else begin
        hrdata_ff <= {24'h0, regs_ff[aSlot]};
      end
    end
  end

  // ****************************************
  // channel decode
  // ****************************************
  logic [7:0] dly4;
  logic [7:0] sup4;
  logic [7:0] trm4;
  logic [2:0] finex4;
  logic [3:0] term4;
  // only channel 4 has delay, supply and termination pages in this bank
  // spare bits above each field are stored but feed no decode, except termination bit 4, the top bit of the three-bit fine delay
  assign dly4   = regs_ff[4'(IDX_OUT4_DELAY - IDX_OUT4_DIVIDE_HIGH)];
  assign sup4   = regs_ff[4'(IDX_OUT4_SUPPLY_DRIVER - IDX_OUT4_DIVIDE_HIGH)];
  assign trm4   = regs_ff[4'(IDX_OUT4_TERMINATION - IDX_OUT4_DIVIDE_HIGH)];
  assign finex4 = {trm4[FINEX_BIT], dly4[FINE_MSB:FINE_LSB]};
  assign term4  = trm4[TERM_MSB:0];

  // divider and phase settings of both channels
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out4DivideRatio       <= 20'h0;
      out4PositivePinSource <= 1'h0;
      out4NegativePinSource <= 1'h1;
      out4DriveStrength     <= 3'h0;
      out5DivideRatio       <= 20'h0;
      out5PositivePinSource <= 1'h0;
      out5NegativePinSource <= 1'h1;
      out5DriveStrength     <= 3'h0;
    end else if (ce) begin
      out4DivideRatio <= divRatio(regs_ff[0], regs_ff[1], regs_ff[2]);
      out5DivideRatio <= divRatio(regs_ff[8], regs_ff[9], regs_ff[10]);
      {out4PositivePinSource, out4NegativePinSource} <= pinSel(regs_ff[3][PHASE_MSB:PHASE_LSB]);
      {out5PositivePinSource, out5NegativePinSource} <= pinSel(regs_ff[11][PHASE_MSB:PHASE_LSB]);
      out4DriveStrength <= regs_ff[3][STR_MSB:0];
      out5DriveStrength <= regs_ff[11][STR_MSB:0];
    end
  end

  // delay settings of channel 4
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out4CoarseDelay    <= 6'h0;
      out4FineDelayPs    <= 8'h0;
      out4ExtFineDelayPs <= 8'h0;
    end else if (ce) begin
      out4CoarseDelay <= dly4[COARSE_MSB:0];
      out4FineDelayPs <= stepsPs({1'h0, dly4[FINE_MSB:FINE_LSB]});
      // three-bit code saturates at four steps
      out4ExtFineDelayPs <= stepsPs((finex4 > FINE_MAX) ? FINE_MAX : finex4);
    end
  end

  // supply, driver and termination of channel 4
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out4SupplyLevelSelect    <= 2'h0;
      out4SupplyValid          <= 1'h1;
      out4DriverStandardSelect <= 3'h0;
      out4DriverValid          <= 1'h1;
      out4ExtTerm              <= 1'h1;
      out4PullUp               <= 1'h0;
      out4PullDown             <= 1'h0;
      out4CmosPos              <= 1'h0;
      out4CmosNeg              <= 1'h0;
      out4TermValid            <= 1'h1;
    end else if (ce) begin
      out4SupplyLevelSelect <= sup4[SUP_MSB:SUP_LSB];
      out4SupplyValid       <= sup4[SUP_MSB:SUP_LSB] != SUP_BAD;
      out4DriverStandardSelect <= sup4[DRV_MSB:0];
      out4DriverValid          <= sup4[DRV_MSB:0] <= DRV_LAST;
      out4ExtTerm  <= term4 == TERM_EXT;
      out4PullUp   <= term4 == TERM_PU;
      out4PullDown <= term4 == TERM_PD;
      out4CmosPos   <= (term4 == TERM_CMOSP) || (term4 == TERM_CMOSB);
      out4CmosNeg   <= (term4 == TERM_CMOSN) || (term4 == TERM_CMOSB);
      out4TermValid <= (term4 == TERM_EXT) || (term4 == TERM_PU) || (term4 == TERM_PD)
        || (term4 == TERM_CMOSP) || (term4 == TERM_CMOSN) || (term4 == TERM_CMOSB);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_write_then_read: assert property (
    wrPend_ff && ce ##1 (take && !hwrite && aMapped && aSlot == $past(wrSlot_ff) && !wrPend_ff)
    |=> hrdata[7:0] == $past(hwdata[7:0], 2) && hrdata[31:8] == 24'h0)
    else $error("stored byte not read back");

  a_unmapped_zero: assert property (
    take && !hwrite && !aMapped |=> hrdata == 32'h0)
    else $error("unmapped read not zero");

  a_div_assembly: assert property (
    ce && wrPend_ff && wrSlot_ff == 4'h2 ##1 ce |=> out4DivideRatio[7:0] == $past(hwdata[7:0], 2))
    else $error("divide low byte not applied");

  a_phase_swap: assert property (
    ce && regs_ff[3][PHASE_MSB:PHASE_LSB] == PH_SWAP |=> out4PositivePinSource && !out4NegativePinSource)
    else $error("swapped phase wrong");

  a_coarse_delay: assert property (
    ce |=> out4CoarseDelay == $past(dly4[COARSE_MSB:0]))
    else $error("coarse delay mismatch");

  a_fine_delay: assert property (
    ce && dly4[FINE_MSB:FINE_LSB] == 2'h3 |=> out4FineDelayPs == 8'h5A)
    else $error("fine delay not 90 ps");

  a_ext_fine_cap: assert property (
    ce && finex4 >= FINE_MAX |=> out4ExtFineDelayPs == 8'h78)
    else $error("extended fine delay not capped");

  a_supply_bad: assert property (
    ce |=> out4SupplyValid == ($past(sup4[SUP_MSB:SUP_LSB]) != SUP_BAD))
    else $error("supply validity wrong");

  a_driver_range: assert property (
    ce && sup4[DRV_MSB:0] > DRV_LAST |=> !out4DriverValid)
    else $error("driver code beyond range accepted");

  a_term_pullup: assert property (
    ce && term4 == TERM_PU |=> out4PullUp && !out4PullDown && !out4ExtTerm && !out4CmosPos)
    else $error("pull-up decode wrong");

  a_term_cmos_both: assert property (
    ce && term4 == TERM_CMOSB |=> out4CmosPos && out4CmosNeg && !out4ExtTerm)
    else $error("both-pin CMOS decode wrong");

  c_write_mapped: cover property (take && hwrite && aMapped ##1 wrPend_ff);
  c_read_forward: cover property (take && !hwrite && aMapped && fwd);
  c_unmapped_read: cover property (take && !hwrite && !aMapped);
  c_freeze: cover property (take ##1 !ce ##1 ce);
endmodule

// >>> occb_pkg.sv
// Purpose: constants for the output clock configuration bank
// Assumes: AHB-Lite word access, one register per aligned word
// Notes:   register index times four gives the byte address
package occb_pkg;
  // ****************************************
  // register indices and geometry
  // ****************************************
  localparam int         NUM_SLOTS     = 12;
  localparam logic [7:0] IDX_OUT4_DIVIDE_HIGH    = 8'h30;
  localparam logic [7:0] IDX_OUT4_DIVIDE_MID     = 8'h31;
  localparam logic [7:0] IDX_OUT4_DIVIDE_LOW     = 8'h32;
  localparam logic [7:0] IDX_OUT4_PHASE_STRENGTH = 8'h33;
  localparam logic [7:0] IDX_OUT4_DELAY          = 8'h34;
  localparam logic [7:0] IDX_OUT4_SUPPLY_DRIVER  = 8'h35;
  localparam logic [7:0] IDX_GAP                 = 8'h36;
  localparam logic [7:0] IDX_OUT4_TERMINATION    = 8'h37;
  localparam logic [7:0] IDX_OUT5_DIVIDE_HIGH    = 8'h38;
  localparam logic [7:0] IDX_OUT5_DIVIDE_MID     = 8'h39;
  localparam logic [7:0] IDX_OUT5_DIVIDE_LOW     = 8'h3A;
  localparam logic [7:0] IDX_OUT5_PHASE_STRENGTH = 8'h3B;
  localparam logic [7:0] REG_RST                 = 8'h00;
  // ****************************************
  // field positions
  // ****************************************
  localparam int DIVHI_MSB  = 3;
  localparam int PHASE_MSB  = 7;
  localparam int PHASE_LSB  = 6;
  localparam int STR_MSB    = 2;
  localparam int COARSE_MSB = 5;
  localparam int FINE_MSB   = 7;
  localparam int FINE_LSB   = 6;
  localparam int SUP_MSB    = 4;
  localparam int SUP_LSB    = 3;
  localparam int DRV_MSB    = 2;
  localparam int TERM_MSB   = 3;
  localparam int FINEX_BIT  = 4;
  // ****************************************
  // codes and timing
  // ****************************************
  localparam logic [1:0] PH_NORMAL   = 2'h0;
  localparam logic [1:0] PH_TRUE2    = 2'h1;
  localparam logic [1:0] PH_COMP2    = 2'h2;
  localparam logic [1:0] PH_SWAP     = 2'h3;
  localparam logic [1:0] SUP_BAD     = 2'h3;
  localparam logic [2:0] DRV_LAST    = 3'h5;
  localparam logic [3:0] TERM_EXT    = 4'h0;
  localparam logic [3:0] TERM_PU     = 4'h2;
  localparam logic [3:0] TERM_PD     = 4'h1;
  localparam logic [3:0] TERM_CMOSP  = 4'h4;
  localparam logic [3:0] TERM_CMOSN  = 4'h8;
  localparam logic [3:0] TERM_CMOSB  = 4'hC;
  localparam int         FINE_STEP_PS = 30;
  localparam logic [2:0] FINE_MAX    = 3'h4;
endpackage

// >>> occb_bank_test.sv
// Purpose: self-checking bench for the output clock configuration bank
// Assumes: one AHB-Lite slave, hready looped back from hreadyout
// Notes:   random bytes from a fixed seed, expectations from a shadow copy
`timescale 1ns/1ps
module occb_bank_test;
  import occb_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic        clock = 1'h0;
  logic        nrst = 1'h0;
  logic        ce = 1'h1;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready, hreadyout, hresp;
  logic [31:0] hrdata;
  logic [19:0] out4DivideRatio, out5DivideRatio;
  logic [2:0]  out4DriveStrength, out5DriveStrength, out4DriverStandardSelect;
  logic [5:0]  out4CoarseDelay;
  logic [7:0]  out4FineDelayPs, out4ExtFineDelayPs;
  logic [1:0]  out4SupplyLevelSelect;
  logic        out4PositivePinSource, out4NegativePinSource, out5PositivePinSource;
  logic        out5NegativePinSource, out4SupplyValid, out4DriverValid, out4ExtTerm;
  logic        out4PullUp, out4PullDown, out4CmosPos, out4CmosNeg, out4TermValid;
  logic [7:0]  mem [8'h30:8'h3C];
  integer      seed = 57297;
  int          err_total = 0;
  int          num_checks = 0;

  // clock and single-slave ready loop
  always #4 clock = ~clock;
  assign hready = hreadyout;

  occb_bank dut (
    .clock(clock), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .out4DivideRatio(out4DivideRatio), .out4PositivePinSource(out4PositivePinSource),
    .out4NegativePinSource(out4NegativePinSource), .out4DriveStrength(out4DriveStrength),
    .out4CoarseDelay(out4CoarseDelay), .out4FineDelayPs(out4FineDelayPs), .out4ExtFineDelayPs(out4ExtFineDelayPs),
    .out4SupplyLevelSelect(out4SupplyLevelSelect), .out4SupplyValid(out4SupplyValid),
    .out4DriverStandardSelect(out4DriverStandardSelect), .out4DriverValid(out4DriverValid),
    .out4ExtTerm(out4ExtTerm), .out4PullUp(out4PullUp), .out4PullDown(out4PullDown), .out4CmosPos(out4CmosPos),
    .out4CmosNeg(out4CmosNeg), .out4TermValid(out4TermValid), .out5DivideRatio(out5DivideRatio),
    .out5PositivePinSource(out5PositivePinSource), .out5NegativePinSource(out5NegativePinSource),
    .out5DriveStrength(out5DriveStrength)
  );

  // ****************************************
  // helpers
  // ****************************************
  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // bounded wait for hready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'h1 && n < 40);
    if (hready !== 1'h1) begin
      err_total++;
      $display("Error hready timeout");
      give_verdict();
    end
  endtask

  // one single word transfer, called right after a rising edge, shadow copy follows writes
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    hsel   <= 1'h1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'($random(seed)), wd};
    wait_ready();
    rd = hrdata;
    check("resp", 32'(hresp), 32'h0);
    if (wr && idx != IDX_GAP && idx <= IDX_OUT5_PHASE_STRENGTH) mem[idx] = wd;
  endtask

  task automatic put_reg(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'h1, idx, d, r);
  endtask

  // read every slot, gap and one unmapped word included
  task automatic read_all();
    logic [31:0] r;
    for (int i = 8'h30; i <= 8'h3C; i++) begin
      xfer(1'h0, 8'(i), 8'h0, r);
      check("readback", r, {24'h0, mem[i]});
    end
  endtask

  // pins as {positive, negative}, 1 means complement clock
  function automatic logic [1:0] exp_phase(input logic [1:0] c);
    return {c[1], ~c[0]};
  endfunction

  // {ext, pull-up, pull-down, cmos pos, cmos neg, valid}
  function automatic logic [5:0] exp_term(input logic [3:0] c);
    case (c)
      TERM_EXT:   return 6'h21;
      TERM_PU:    return 6'h11;
      TERM_PD:    return 6'h09;
      TERM_CMOSP: return 6'h05;
      TERM_CMOSN: return 6'h03;
      TERM_CMOSB: return 6'h07;
      default:    return 6'h00;
    endcase
  endfunction

  // decoded settings against the shadow copy
  task automatic chk_out();
    logic [2:0] fx;
    logic [5:0] tm;
    logic [7:0] s;
    fx = {mem[8'h37][FINEX_BIT], mem[8'h34][7:6]};
    tm = exp_term(mem[8'h37][3:0]);
    s = mem[8'h35];
    check("ratio4", 32'(out4DivideRatio), {12'h0, mem[8'h30][3:0], mem[8'h31], mem[8'h32]});
    check("ratio5", 32'(out5DivideRatio), {12'h0, mem[8'h38][3:0], mem[8'h39], mem[8'h3A]});
    check("pins4", 32'({out4PositivePinSource, out4NegativePinSource}), 32'(exp_phase(mem[8'h33][7:6])));
    check("pins5", 32'({out5PositivePinSource, out5NegativePinSource}), 32'(exp_phase(mem[8'h3B][7:6])));
    check("str4", 32'(out4DriveStrength), 32'(mem[8'h33][2:0]));
    check("str5", 32'(out5DriveStrength), 32'(mem[8'h3B][2:0]));
    check("coarse", 32'(out4CoarseDelay), 32'(mem[8'h34][5:0]));
    check("fine", 32'(out4FineDelayPs), 32'(mem[8'h34][7:6]) * 30);
    check("extfine", 32'(out4ExtFineDelayPs), 32'(fx > 3'h4 ? 3'h4 : fx) * 30);
    check("supply", 32'({out4SupplyValid, out4SupplyLevelSelect}), 32'({s[4:3] != 2'h3, s[4:3]}));
    check("driver", 32'({out4DriverValid, out4DriverStandardSelect}), 32'({s[2:0] <= 3'h5, s[2:0]}));
    check("termok", 32'(out4TermValid), 32'(tm[0]));
    check("term", 32'({out4ExtTerm, out4PullUp, out4PullDown, out4CmosPos, out4CmosNeg}), 32'(tm[5:1]));
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0]  b;
    logic [4:0]  c;
    logic [31:0] r;
    for (int i = 8'h30; i <= 8'h3C; i++) mem[i] = 8'h0;
    repeat (10) @(posedge clock);
    nrst <= 1'h1;
    chk_out();
    read_all();
    // every supply, driver, termination and phase code, random spare bits
    for (int i = 0; i < 32; i++) begin
      c = 5'(i);
      for (int a = 8'h30; a <= 8'h3C; a++) put_reg(8'(a), 8'($random(seed)));
      b = 8'($random(seed));
      put_reg(IDX_OUT4_SUPPLY_DRIVER, {b[7:5], c});
      put_reg(IDX_OUT4_TERMINATION, {b[7:4], c[3:0]});
      put_reg(IDX_OUT5_PHASE_STRENGTH, {c[3:2], b[5:0]});
      put_reg(IDX_OUT4_PHASE_STRENGTH, {c[1:0], b[2:0], 3'h7});
      // read straight after the write to the same word
      xfer(1'h0, IDX_OUT4_PHASE_STRENGTH, 8'h0, r);
      check("wrrd", r, {24'h0, mem[IDX_OUT4_PHASE_STRENGTH]});
      repeat (2) @(posedge clock);
      chk_out();
      read_all();
    end
    // clock enable low in the data phase stalls a write for one cycle
    fork
      put_reg(IDX_OUT4_DIVIDE_LOW, 8'hA5);
      begin
        @(posedge clock);
        ce <= 1'h0;
        @(posedge clock);
        check("stall", 32'(hreadyout), 32'h0);
        ce <= 1'h1;
      end
    join
    repeat (2) @(posedge clock);
    chk_out();
    // second reset in mid-run clears every byte
    nrst <= 1'h0;
    for (int i = 8'h30; i <= 8'h3C; i++) mem[i] = 8'h0;
    repeat (3) @(posedge clock);
    chk_out();
    nrst <= 1'h1;
    read_all();
    give_verdict();
  end
endmodule
